/* design/eeprom_pkg.sv */
// Summary of operation
// - First byte after start is the control byte; respond only if its device code matches.
// - The three bits after the device code are ignored.
// - Control byte bit 0 selects read when 1, write when 0.
// - Acknowledge a matching control byte, then enter the selected read or write flow.
// - Second write byte is the word address; only its seven low bits are kept.
// - Byte write: control, address, one data byte, each acknowledged; address loads pointer.
// - Stop after a write starts the timed write cycle; no acknowledge until it ends.
// - Up to eight data bytes held in a page buffer, committed only after stop.
// - Each data byte increments the pointer's in-page bits; page bits stay fixed.
// - More than eight bytes roll over in the page, replacing earlier bytes in order.
// - Page writes wrap inside one aligned page and never enter the next page.
// - Protect strap high blocks writes to the upper half; low allows all writes.
// - Host may poll with a write control byte; acknowledged only when idle.
// - Current-address read sends the byte one past the last accessed location.
// - Host no-acknowledge plus stop ends a read; device releases the data line.
// - Random read: word address latched before the repeated start aborts the write.
// - Host acknowledge after a read byte makes the device send the next byte.
// - Pointer increments after every byte read so all memory reads sequentially.
// - Start is data falling with clock high; stop is data rising with clock high.
package eeprom_pkg;
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 128;
  localparam int PAGE_BYTES = 8;
  localparam int PAGE_IDX_W = 3;
  localparam int PROTECT_BIT = 6;
  localparam logic [7:0] ERASED_VALUE = 8'hff;
  // Value is arbitrary
  localparam logic [3:0] DEV_CODE_DEFAULT = 4'h5;
  localparam int CLK_HZ = 10_000_000;
  localparam int TWC_MS = 5;
  localparam int TWC_CYCLES = TWC_MS * (CLK_HZ / 1000);
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WP_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;
  localparam int ST_PTR_LSB = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } bus_state_t;

  typedef enum logic [3:0] {
    PH_CTRL = 4'h1,
    PH_ADDR = 4'h2,
    PH_DATA = 4'h4,
    PH_READ = 4'h8
  } phase_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic [MEM_WORDS-1:0][7:0] cells;
  } mem_state_t;
endpackage

/* design/eeprom_cells.sv */
`timescale 1ns/10ps
module eeprom_cells (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire eeprom_pkg::mem_wr_t wr,
  input wire logic [eeprom_pkg::ADDR_W-1:0] raddr,
  output logic [7:0] rdata
);
  eeprom_pkg::mem_state_t r_reg;
  eeprom_pkg::mem_state_t r_next;

  always_comb
  begin
    r_next = r_reg;
    if (wr.en)
    begin
      r_next.cells[wr.addr] = wr.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= {eeprom_pkg::MEM_WORDS{eeprom_pkg::ERASED_VALUE}};
    end
    else if (ce)
    begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.cells[raddr];
endmodule

/* design/eeprom_client.sv */
`timescale 1ns/10ps
module eeprom_client #(
  parameter int WRITE_CYCLES = eeprom_pkg::TWC_CYCLES,
  parameter logic [3:0] DEVICE_CODE = eeprom_pkg::DEV_CODE_DEFAULT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp_in
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic wp_m;
    logic wp_s;
    eeprom_pkg::bus_state_t st;
    eeprom_pkg::phase_t ph;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic host_ack;
    logic sda_oe;
    logic sda_out;
    logic [eeprom_pkg::ADDR_W-1:0] ptr;
    logic [eeprom_pkg::ADDR_W-eeprom_pkg::PAGE_IDX_W-1:0] page;
    logic [eeprom_pkg::PAGE_BYTES-1:0][7:0] pbuf;
    logic [eeprom_pkg::PAGE_BYTES-1:0] valid;
    logic busy;
    logic [3:0] commit_idx;
    logic [15:0] timer;
    logic ctrl_en;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } state_t;

  state_t r_reg;
  state_t r_next;
  eeprom_pkg::mem_wr_t mem_wr;
  logic [7:0] mem_rdata;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic code_match;
  logic ahb_sel;
  logic addr_hit_hi;
  logic [31:0] status_word;
  logic [15:0] twc_last;

  assign twc_last = 16'(WRITE_CYCLES - 1);
  assign scl_rise = r_reg.scl_s & ~r_reg.scl_p;
  assign scl_fall = ~r_reg.scl_s & r_reg.scl_p;
  assign start_det = r_reg.scl_s & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_s;
  assign stop_det = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_s;
  assign byte_done = (r_reg.st == eeprom_pkg::ST_RX) && scl_fall && (r_reg.bitcnt == 4'h8);
  assign code_match = (r_reg.shift[7:4] == DEVICE_CODE);
  assign ahb_sel = hsel & htrans[1] & hready;
  assign addr_hit_hi = (haddr[31:8] == 24'h000000);

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[eeprom_pkg::ST_BUSY_BIT] = r_reg.busy;
    status_word[eeprom_pkg::ST_WP_BIT] = r_reg.wp_s;
    status_word[eeprom_pkg::ST_ACTIVE_BIT] = (r_reg.st != eeprom_pkg::ST_IDLE);
    status_word[eeprom_pkg::ST_PTR_LSB +: eeprom_pkg::ADDR_W] = r_reg.ptr;
  end

  eeprom_cells u_cells (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .wr(mem_wr),
    .raddr(r_reg.ptr),
    .rdata(mem_rdata)
  );

  always_comb
  begin
    r_next = r_reg;
    mem_wr = '0;
    // Pins cross into hclk through two flops before use
    r_next.scl_m = scl_in;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_p = r_reg.scl_s;
    r_next.sda_m = sda_in;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_p = r_reg.sda_s;
    r_next.wp_m = wp_in;
    r_next.wp_s = r_reg.wp_m;
    r_next.sda_out = 1'b0;

    if (start_det)
    begin
      r_next.st = eeprom_pkg::ST_RX;
      r_next.ph = eeprom_pkg::PH_CTRL;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end
    else if (stop_det)
    begin
      if (r_reg.ph == eeprom_pkg::PH_DATA && |r_reg.valid && !r_reg.busy)
      begin
        r_next.busy = 1'b1;
        r_next.commit_idx = 4'h0;
        r_next.timer = 16'h0000;
      end
      r_next.st = eeprom_pkg::ST_IDLE;
      r_next.ph = eeprom_pkg::PH_CTRL;
      r_next.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r_reg.st)
        eeprom_pkg::ST_IDLE:
        begin
          r_next.sda_oe = 1'b0;
        end
        eeprom_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          else if (byte_done)
          begin
            r_next.bitcnt = 4'h0;
            r_next.st = eeprom_pkg::ST_ACK;
            r_next.sda_oe = 1'b1;
            unique case (r_reg.ph)
              eeprom_pkg::PH_CTRL:
              begin
                // ack only a matching, idle device
                if (code_match && !r_reg.busy && r_reg.ctrl_en)
                begin
                  r_next.ph = r_reg.shift[0] ? eeprom_pkg::PH_READ : eeprom_pkg::PH_ADDR;
                end
                else
                begin
                  r_next.st = eeprom_pkg::ST_IDLE;
                  r_next.sda_oe = 1'b0;
                end
              end
              eeprom_pkg::PH_ADDR:
              begin
                r_next.ptr = r_reg.shift[eeprom_pkg::ADDR_W-1:0];
                r_next.page = r_reg.shift[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_IDX_W];
                r_next.valid = '0;
                r_next.ph = eeprom_pkg::PH_DATA;
              end
              eeprom_pkg::PH_DATA:
              begin
                r_next.pbuf[r_reg.ptr[eeprom_pkg::PAGE_IDX_W-1:0]] = r_reg.shift;
                r_next.valid[r_reg.ptr[eeprom_pkg::PAGE_IDX_W-1:0]] = 1'b1;
                r_next.ptr[eeprom_pkg::PAGE_IDX_W-1:0] = r_reg.ptr[eeprom_pkg::PAGE_IDX_W-1:0] + 3'h1;
              end
              eeprom_pkg::PH_READ:
              begin
                r_next.st = eeprom_pkg::ST_IDLE;
                r_next.sda_oe = 1'b0;
              end
            endcase
          end
        end
        eeprom_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            r_next.sda_oe = 1'b0;
            r_next.bitcnt = 4'h0;
            if (r_reg.ph == eeprom_pkg::PH_READ)
            begin
              r_next.shift = mem_rdata;
              r_next.ptr = r_reg.ptr + 7'h01;
              r_next.sda_oe = ~mem_rdata[7];
              r_next.st = eeprom_pkg::ST_TX;
            end
            else
            begin
              r_next.st = eeprom_pkg::ST_RX;
            end
          end
        end
        eeprom_pkg::ST_TX:
        begin
          if (scl_rise)
          begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (r_reg.bitcnt == 4'h8)
            begin
              r_next.st = eeprom_pkg::ST_TXACK;
              r_next.sda_oe = 1'b0;
            end
            else
            begin
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shift[6];
            end
          end
        end
        eeprom_pkg::ST_TXACK:
        begin
          if (scl_rise)
          begin
            r_next.host_ack = ~r_reg.sda_s;
          end
          else if (scl_fall)
          begin
            r_next.bitcnt = 4'h0;
            if (r_reg.host_ack)
            begin
              r_next.shift = mem_rdata;
              r_next.ptr = r_reg.ptr + 7'h01;
              r_next.sda_oe = ~mem_rdata[7];
              r_next.st = eeprom_pkg::ST_TX;
            end
            else
            begin
              r_next.st = eeprom_pkg::ST_IDLE;
              r_next.sda_oe = 1'b0;
            end
          end
        end
      endcase
    end

    // Buffer drains in eight cycles, then the cell timer runs
    if (r_reg.busy)
    begin
      if (!r_reg.commit_idx[3])
      begin
        mem_wr.en = r_reg.valid[r_reg.commit_idx[2:0]] &&
                    !(r_reg.wp_s && r_reg.page[eeprom_pkg::PROTECT_BIT-eeprom_pkg::PAGE_IDX_W]);
        mem_wr.addr = {r_reg.page, r_reg.commit_idx[2:0]};
        mem_wr.data = r_reg.pbuf[r_reg.commit_idx[2:0]];
        r_next.commit_idx = r_reg.commit_idx + 4'h1;
      end
      else if (r_reg.timer >= twc_last)
      begin
        r_next.busy = 1'b0;
        r_next.valid = '0;
      end
      else
      begin
        r_next.timer = r_reg.timer + 16'h0001;
      end
    end

    // Bus slave: zero wait states, unmapped reads return zero
    r_next.hreadyout = 1'b1;
    r_next.hresp = 1'b0;
    if (r_reg.wr_pend)
    begin
      r_next.wr_pend = 1'b0;
      if (r_reg.wr_addr == eeprom_pkg::CTRL_OFS)
      begin
        r_next.ctrl_en = hwdata[eeprom_pkg::CTRL_EN_BIT];
      end
    end
    if (ahb_sel)
    begin
      if (hwrite)
      begin
        r_next.wr_pend = addr_hit_hi && (hsize == eeprom_pkg::HSIZE_WORD);
        r_next.wr_addr = haddr[7:0];
      end
      else if (addr_hit_hi && haddr[7:0] == eeprom_pkg::CTRL_OFS)
      begin
        r_next.hrdata = {31'h00000000, r_reg.ctrl_en};
      end
      else if (addr_hit_hi && haddr[7:0] == eeprom_pkg::STATUS_OFS)
      begin
        r_next.hrdata = status_word;
      end
      else
      begin
        r_next.hrdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
      r_reg.scl_m <= 1'b1;
      r_reg.scl_s <= 1'b1;
      r_reg.scl_p <= 1'b1;
      r_reg.sda_m <= 1'b1;
      r_reg.sda_s <= 1'b1;
      r_reg.sda_p <= 1'b1;
      r_reg.st <= eeprom_pkg::ST_IDLE;
      r_reg.ph <= eeprom_pkg::PH_CTRL;
      r_reg.ctrl_en <= eeprom_pkg::CTRL_EN_RESET;
      r_reg.hreadyout <= 1'b1;
    end
    else if (ce)
    begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.hreadyout;
  assign hresp = r_reg.hresp;
  assign hrdata = r_reg.hrdata;
  assign sda_out = r_reg.sda_out;
  assign sda_oe = r_reg.sda_oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !ce);

  a_busy_no_ack: assert property (byte_done && r_reg.busy |=> !r_reg.sda_oe)
    else $error("ack given during write cycle");
  a_code_mismatch: assert property (byte_done && r_reg.ph == eeprom_pkg::PH_CTRL && !code_match
    |=> r_reg.st == eeprom_pkg::ST_IDLE && !r_reg.sda_oe)
    else $error("foreign control byte answered");
  a_ctrl_ack: assert property (byte_done && r_reg.ph == eeprom_pkg::PH_CTRL && code_match && !r_reg.busy
    && r_reg.ctrl_en |=> r_reg.sda_oe && r_reg.st == eeprom_pkg::ST_ACK)
    else $error("matching control byte not acked");
  a_dir_select: assert property (byte_done && r_reg.ph == eeprom_pkg::PH_CTRL && code_match && !r_reg.busy
    && r_reg.ctrl_en |=> r_reg.ph == ($past(r_reg.shift[0]) ? eeprom_pkg::PH_READ : eeprom_pkg::PH_ADDR))
    else $error("wrong direction taken");
  a_addr_latch: assert property (byte_done && r_reg.ph == eeprom_pkg::PH_ADDR
    |=> r_reg.ptr == $past(r_reg.shift[6:0]))
    else $error("word address not latched");
  a_page_wrap: assert property (byte_done && r_reg.ph == eeprom_pkg::PH_DATA
    |=> r_reg.ptr[6:3] == $past(r_reg.ptr[6:3]) && r_reg.ptr[2:0] == 3'($past(r_reg.ptr[2:0]) + 3'h1))
    else $error("page pointer left its page");
  a_stop_commit: assert property (stop_det && r_reg.ph == eeprom_pkg::PH_DATA && |r_reg.valid && !r_reg.busy
    |=> r_reg.busy [*8])
    else $error("stop did not start write cycle");
  a_protect_half: assert property (mem_wr.en |-> !(r_reg.wp_s && mem_wr.addr[eeprom_pkg::PROTECT_BIT]))
    else $error("protected cell written");
  a_read_advance: assert property (r_reg.st == eeprom_pkg::ST_ACK && scl_fall && r_reg.ph == eeprom_pkg::PH_READ
    |=> r_reg.ptr == 7'($past(r_reg.ptr) + 7'h01) && r_reg.st == eeprom_pkg::ST_TX)
    else $error("read pointer not advanced");
  a_nack_release: assert property (r_reg.st == eeprom_pkg::ST_TXACK && scl_fall && !r_reg.host_ack
    |=> !r_reg.sda_oe && r_reg.st == eeprom_pkg::ST_IDLE)
    else $error("line held after host nack");
  a_seq_next: assert property (r_reg.st == eeprom_pkg::ST_TXACK && scl_fall && r_reg.host_ack
    |=> r_reg.st == eeprom_pkg::ST_TX)
    else $error("sequential read stalled");
  a_start_seen: assert property (start_det |=> r_reg.st == eeprom_pkg::ST_RX && r_reg.ph == eeprom_pkg::PH_CTRL)
    else $error("start not recognised");

  c_write_cycle: cover property ($rose(r_reg.busy));
  c_seq_read: cover property (r_reg.st == eeprom_pkg::ST_TXACK && scl_fall && r_reg.host_ack);
  c_poll_refused: cover property (byte_done && r_reg.busy && code_match);
  c_protect_skip: cover property (r_reg.busy && !r_reg.commit_idx[3] && r_reg.wp_s && r_reg.page[3]);
endmodule

/* verification/twowire_host.sv */
`timescale 1ns/10ps
module twowire_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // start: data falls with clock high
  task automatic start();
    #250;
    sda_low = 1'b0;
    #250;
    scl = 1'b1;
    #300;
    sda_low = 1'b1;
    #300;
    scl = 1'b0;
  endtask

  // stop: data rises with clock high
  task automatic stop();
    #250;
    sda_low = 1'b1;
    #250;
    scl = 1'b1;
    #300;
    sda_low = 1'b0;
    #300;
  endtask

  // Long low phase leaves room for the client's late data change
  task automatic bit_io(input logic b, output logic s);
    #250;
    sda_low = ~b;
    #250;
    scl = 1'b1;
    #250;
    s = sda;
    #50;
    scl = 1'b0;
  endtask

  // host sends bytes MSB first and releases for the ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // ack to continue, withhold it on the final byte
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

/* verification/eeprom_client_tb.sv */
`timescale 1ns/10ps
module eeprom_client_tb;
  localparam int WCYC = 400;
  localparam logic [3:0] CODE = eeprom_pkg::DEV_CODE_DEFAULT;
  localparam logic [31:0] ST_A = 32'(eeprom_pkg::STATUS_OFS);
  localparam logic [31:0] CT_A = 32'(eeprom_pkg::CTRL_OFS);
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = eeprom_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic wp_in = 1'b0;
  logic hreadyout, hresp, sda_out, sda_oe, scl, host_low;
  logic [31:0] hrdata;
  wire sda_w;
  int errors = 0;
  int n_checks = 0;
  logic [7:0] exp_mem [128];

  // Open drain with pull-up: low when anyone pulls
  assign sda_w = ~(host_low | (sda_oe & ~sda_out));

  always #50 hclk = ~hclk;

  eeprom_client #(.WRITE_CYCLES(WCYC), .DEVICE_CODE(CODE)) i_eeprom_client (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(1'b1),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wp_in(wp_in)
  );

  twowire_host i_twowire_host (.scl(scl), .sda_low(host_low), .sda(sda_w));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t %s: got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    // A slave that never answers must fail the run, not stall it
    if (hreadyout !== 1'b1)
    begin
      errors++;
      $display("BAD t=%0t ready timeout", $time);
    end
  endtask

  task automatic ahb_req(input logic [31:0] a, input logic wr);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= eeprom_pkg::HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
  endtask

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    ahb_req(a, 1'b1);
    hwdata <= d;
    wait_ready();
  endtask

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    ahb_req(a, 1'b0);
    wait_ready();
    d = hrdata;
    chk(hresp, 1'b0, "okay response");
  endtask

  // Control byte only, then stop; reports the ack
  task automatic probe(input logic [7:0] c, output logic ack);
    i_twowire_host.start();
    i_twowire_host.put_byte(c, ack);
    i_twowire_host.stop();
  endtask

  task automatic poll_done();
    logic ack;
    int n;
    n = 0;
    ack = 1'b0;
    while (!ack && n < 20)
    begin
      probe({CODE, 3'h0, 1'b0}, ack);
      if (n == 0)
        chk(ack, 1'b0, "ack while busy");
      n++;
    end
    chk(ack, 1'b1, "ack after write cycle");
  endtask

  task automatic wr_page(input logic [7:0] a, input int n, input logic [7:0] base);
    logic ack;
    logic [31:0] st;
    logic [6:0] p;
    p = a[6:0];
    i_twowire_host.start();
    i_twowire_host.put_byte({CODE, 3'h5, 1'b0}, ack);
    chk(ack, 1'b1, "ctrl ack");
    i_twowire_host.put_byte(a, ack);
    chk(ack, 1'b1, "addr ack");
    for (int i = 0; i < n; i++)
    begin
      i_twowire_host.put_byte(base + 8'(i), ack);
      chk(ack, 1'b1, "data ack");
      if (!(wp_in && p[6]))
        exp_mem[p] = base + 8'(i);
      p = {p[6:3], p[2:0] + 3'h1};
    end
    i_twowire_host.stop();
    ahb_read(ST_A, st);
    chk(st[0], 1'b1, "busy after stop");
    poll_done();
    ahb_read(ST_A, st);
    chk(st[14:8], p, "pointer after write");
  endtask

  task automatic rd_seq(input logic [6:0] a, input int n, input logic set);
    logic ack;
    logic [7:0] b;
    logic [31:0] st;
    if (set)
    begin
      i_twowire_host.start();
      i_twowire_host.put_byte({CODE, 3'h2, 1'b0}, ack);
      i_twowire_host.put_byte({1'b1, a}, ack);
    end
    i_twowire_host.start();
    i_twowire_host.put_byte({CODE, 3'h7, 1'b1}, ack);
    chk(ack, 1'b1, "read ctrl ack");
    for (int i = 0; i < n; i++)
    begin
      i_twowire_host.get_byte(i < n - 1, b);
      chk(b, exp_mem[a + 7'(i)], "read data");
    end
    i_twowire_host.stop();
    chk(sda_oe, 1'b0, "line released");
    ahb_read(ST_A, st);
    chk(st[14:8], 7'(a + 7'(n)), "pointer after read");
  endtask

  initial
  begin
    logic [31:0] d;
    logic ack;
    for (int i = 0; i < 128; i++)
      exp_mem[i] = eeprom_pkg::ERASED_VALUE;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(sda_oe, 1'b0, "oe after reset");
    chk(sda_out, 1'b0, "out after reset");
    ahb_read(CT_A, d);
    chk(d[0], 1'b1, "enable after reset");
    ahb_read(ST_A, d);
    chk(d, 32'h0, "status after reset");
    ahb_read(32'h8, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      probe({CODE, 3'(k), 1'b0}, ack);
      chk(ack, 1'b1, "any middle bits");
    end
    probe({~CODE, 4'h0}, ack);
    chk(ack, 1'b0, "foreign code");
    ahb_write(CT_A, 32'h0);
    probe({CODE, 4'h0}, ack);
    chk(ack, 1'b0, "respond disabled");
    ahb_write(CT_A, 32'h1);
    $display("test addressing done");
    wr_page(8'h85, 1, 8'h3c);
    rd_seq(7'h04, 1, 1'b1);
    rd_seq(7'h05, 1, 1'b0);
    $display("test byte write done");
    // runs past the page end on purpose to show the wrap
    wr_page(8'h16, 10, 8'ha0);
    rd_seq(7'h0f, 11, 1'b1);
    $display("test page write done");
    wp_in <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb_read(ST_A, d);
    chk(d[1], 1'b1, "strap seen");
    wr_page(8'h3f, 1, 8'h61);
    wr_page(8'h40, 2, 8'h72);
    rd_seq(7'h3f, 3, 1'b1);
    wp_in <= 1'b0;
    repeat (4) @(posedge hclk);
    wr_page(8'h41, 1, 8'h99);
    rd_seq(7'h40, 2, 1'b1);
    $display("test protect done");
    rd_seq(7'h7e, 8, 1'b1);
    $display("test wrap read done");
    give_verdict();
  end

  initial
  begin
    #8_000_000;
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule
